// >>> icu_pkg.sv
/*
  shared layouts, states and constants for the interrupt control unit:
  control word fields, host strobe bundle, acknowledge byte counts.
  assumes a single clock domain; all control word layouts are 8-bit host words.
*/
package icu_pkg;

  localparam int          ICU_N          = 8;
  localparam int          ICU_W          = 3;
  localparam logic [7:0]  ICU_CALL_OPCODE = 8'hcd;
  localparam logic [2:0]  ICU_LOWEST_RST = 3'h7;
  localparam logic [7:0]  ICU_BYTE_CLR   = 8'h00;
  localparam logic [7:0]  ICU_EDGE_RST   = 8'hff;
  localparam logic [1:0]  ICU_CALL_BYTES = 2'h3;
  localparam logic [1:0]  ICU_VEC_BYTES  = 2'h2;
  localparam logic [1:0]  ICU_BYTE_FIRST = 2'h0;
  localparam logic [1:0]  ICU_BYTE_SECOND = 2'h1;

  // init sequence, gray along the usual path
  typedef enum logic [1:0] {
    ICU_READY = 2'b00,
    ICU_WAIT2 = 2'b01,
    ICU_WAIT3 = 2'b11,
    ICU_WAIT4 = 2'b10
  } icu_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        a0;
    logic [7:0]  wdata;
  } icu_host_t;

  typedef struct packed {
    logic [2:0]  addr_lo;
    logic        mark;
    logic        sensitivity_select;
    logic        spacing_select;
    logic        standalone_select;
    logic        fourth_word_needed;
  } icu_iw1_t;

  typedef struct packed {
    logic [2:0]  zero;
    logic        extended_nest_select;
    logic        buffered;
    logic        buffered_role_bit;
    logic        auto_end_of_service;
    logic        vector_mode;
  } icu_iw4_t;

  typedef struct packed {
    logic        rotate_bit;
    logic        specify_level_bit;
    logic        end_of_service_bit;
    logic        sel4;
    logic        sel3;
    logic [2:0]  target_priority_slot;
  } icu_pfc_t;

  typedef struct packed {
    logic        unused;
    logic        nest_change_enable;
    logic        special_nest_select;
    logic        sel4;
    logic        sel3;
    logic        query_command;
    logic        read_select_enable;
    logic        read_target_select;
  } icu_mode_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  zero;
    logic [2:0]  slot;
  } icu_poll_t;

endpackage : icu_pkg

// >>> icu_prio_resolve.sv
/*
  circular priority resolver: picks the highest-ranked candidate that
  outranks every blocking bit (or equals the highest one when equal_ok is set), starting just above the lowest slot.
  purely combinational; caller registers the result.
*/
`timescale 1ns/1ps
module icu_prio_resolve #(
  parameter int N = 8,
  parameter int W = 3
) (
  // candidates and blockers
  input  wire logic [N-1:0] cand,
  input  wire logic [N-1:0] block,
  input  wire logic [W-1:0] lowest,
  input  wire logic         equal_ok,
  // result
  output logic              valid,
  output logic [W-1:0]      slot
);

  logic         stop;
  logic [W-1:0] idx;

  always_comb
  begin
    valid = 1'b0;
    slot  = '0;
    stop  = 1'b0;
    idx   = '0;
    for (int k = 0; k < N; k++)
    begin
      idx = W'(lowest + W'(1) + W'(k));
      if (!stop && !valid && cand[idx] && (!block[idx] || equal_ok))
      begin
        valid = 1'b1;
        slot  = idx;
      end
      if (block[idx])
        stop = 1'b1;
    end
  end

endmodule : icu_prio_resolve

// >>> icu_core.sv
/*
  control-word front end and request logic of an eight-input interrupt
  control unit: init sequence, mask, priority/finish and mode words,
  pending/in-service tracking, acknowledge byte output, cascade select.
  assumes host strobes are synchronous to clk; request, acknowledge,
  role and cascade pins are asynchronous and synchronised here.
*/
// Overview of operation
// - low-address write with bit4 starts init
// - init clears edge state, edge pending, service, mask
// - init cancels special nesting, reads pending
// - init clears fourth word to defaults
// - third/fourth words follow per first-word bits
// - first word fields: address, sense, spacing, size
// - sense bit picks level or rising edge
// - call addresses spaced four or eight bytes
// - standalone ignores role; else cascaded mode
// - second word holds high address/vector bits
// - master from pin or buffered role bit
// - master flags slave inputs, drives cascade number
// - slave answers only on matching cascade number
// - fourth word bit4 picks nesting style
// - bit3 buffered mode, bit2 buffered role
// - bit1 auto clears in-service at end
// - bit0 picks vector or call response
// - mask blocks pending; special nest masks service
// - priority/finish command field layout
// - circular priority, seven lowest after init
// - specify-level names rotate or finish slot
// - mode word sets nesting, read target, polling
// - normal nesting admits strictly higher only
// - vector byte is upper bits plus level
`timescale 1ns/1ps
module icu_core (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  // host control words
  input  wire icu_pkg::icu_host_t    host,
  output logic [7:0]                 rd_data,
  // request and acknowledge pins
  input  wire logic [7:0]            request_input,
  input  wire logic                  acknowledge_strobe_n,
  output logic                       int_req,
  output logic [7:0]                 data_out,
  output logic                       data_oe,
  // role pin, doubles as buffer direction
  input  wire logic                  role_select_pin_in,
  output logic                       role_select_pin_out,
  output logic                       role_select_pin_oe,
  // cascade select bus
  input  wire logic [2:0]            cascade_select_bus_in,
  output logic [2:0]                 cascade_select_bus_out,
  output logic                       cascade_select_bus_oe
);
  import icu_pkg::*;

  icu_state_t          state_reg;
  icu_iw1_t            iw1_reg;
  icu_iw4_t            iw4_reg;
  logic [7:0]          iw2_reg, iw3_reg, mask_reg, isr_reg, pend_reg;
  logic [7:0]          req_s1, req_s2, req_prev, isr_next, pend_next;
  logic                ack_s1, ack_s2, ack_prev, role_s1, role_s2;
  logic [2:0]          cas_s1, cas_s2, lowest_reg, ack_slot_reg, cur_slot;
  logic                special_reg, read_isr_reg, poll_reg, int_req_reg;
  logic [7:0]          rd_data_reg, data_reg, byte_next;
  logic                data_oe_reg, cas_oe_reg, sv_out_reg, sv_oe_reg;
  logic [2:0]          cas_out_reg;
  logic [1:0]          ack_cnt_reg, ack_total;
  logic                wr, w1, wa1, mask_wr, pfc_wr, mode_wr, rd;
  logic                single, master, slave, resp, oe_next;
  logic                ack_fall, ack_rise, ack_end, res_valid, hi_valid;
  logic [2:0]          res_slot, hi_slot;
  logic [7:0]          isr_eff, pend_eff;
  icu_iw1_t            wd_iw1;
  icu_pfc_t            wd_pfc;
  icu_mode_t           wd_mode;
  icu_poll_t           poll_word;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // pin synchronisers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_s1 <= ICU_BYTE_CLR;
      req_s2 <= ICU_BYTE_CLR;
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      ack_prev <= 1'b1;
      role_s1 <= 1'b1;
      role_s2 <= 1'b1;
      cas_s1 <= '0;
      cas_s2 <= '0;
    end
    else if (ce)
    begin
      req_s1 <= request_input;
      req_s2 <= req_s1;
      ack_s1 <= acknowledge_strobe_n;
      ack_s2 <= ack_s1;
      ack_prev <= ack_s2;
      role_s1 <= role_select_pin_in;
      role_s2 <= role_s1;
      cas_s1 <= cascade_select_bus_in;
      cas_s2 <= cas_s1;
    end
  end

  // word decode
  always_comb
  begin
    wd_iw1  = icu_iw1_t'(host.wdata);
    wd_pfc  = icu_pfc_t'(host.wdata);
    wd_mode = icu_mode_t'(host.wdata);
    wr      = ce && host.wr;
    rd      = ce && host.rd;
    // bit4 on low address always restarts init
    w1      = wr && !host.a0 && wd_iw1.mark;
    // high address goes to init words, then mask
    wa1     = wr && host.a0;
    mask_wr = wa1 && state_reg == ICU_READY;
    // command word has zeros in bits 4 and 3
    pfc_wr  = wr && !host.a0 && !wd_pfc.sel4 && !wd_pfc.sel3;
    // mode word recognised by bits 4,3 = 0,1
    mode_wr = wr && !host.a0 && !wd_mode.sel4 && wd_mode.sel3;
  end

  // role from pin unless buffered, then role bit
  always_comb
  begin
    single = iw1_reg.standalone_select;
    master = !single && (iw4_reg.buffered ? iw4_reg.buffered_role_bit : role_s2);
    slave  = !single && !master;
  end

  // second word is the next high-address write
  // third word only cascaded, fourth only if asked
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ICU_READY;
    else if (ce)
    begin
      if (w1)
        state_reg <= ICU_WAIT2;
      else if (wa1)
      begin
        unique case (state_reg)
          ICU_WAIT2:
            if (!iw1_reg.standalone_select)
              state_reg <= ICU_WAIT3;
            else if (iw1_reg.fourth_word_needed)
              state_reg <= ICU_WAIT4;
            else
              state_reg <= ICU_READY;
          ICU_WAIT3:
            state_reg <= iw1_reg.fourth_word_needed ? ICU_WAIT4 : ICU_READY;
          ICU_WAIT4:
            state_reg <= ICU_READY;
          ICU_READY:
            state_reg <= ICU_READY;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      iw1_reg <= icu_iw1_t'(ICU_BYTE_CLR);
      iw2_reg <= ICU_BYTE_CLR;
      iw3_reg <= ICU_BYTE_CLR;
    end
    else if (ce)
    begin
      if (w1)
        iw1_reg <= wd_iw1;
      if (wa1 && state_reg == ICU_WAIT2)
        iw2_reg <= host.wdata;
      if (wa1 && state_reg == ICU_WAIT3)
        iw3_reg <= host.wdata;
    end
  end

  // init clears fourth word to all defaults
  // nesting, buffer, finish and cpu style
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      iw4_reg <= icu_iw4_t'(ICU_BYTE_CLR);
    else if (ce)
    begin
      if (w1)
        iw4_reg <= icu_iw4_t'(ICU_BYTE_CLR);
      else if (wa1 && state_reg == ICU_WAIT4)
        iw4_reg <= icu_iw4_t'(host.wdata);
    end
  end

  // init clears mask; mask word loads it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_reg <= ICU_BYTE_CLR;
    else if (ce)
    begin
      if (w1)
        mask_reg <= ICU_BYTE_CLR;
      else if (mask_wr)
        mask_reg <= host.wdata;
    end
  end

  // init restores normal nesting and pending reads
  // mode word nesting, read target and poll request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      special_reg  <= 1'b0;
      read_isr_reg <= 1'b0;
      poll_reg     <= 1'b0;
    end
    else if (ce)
    begin
      if (w1)
      begin
        special_reg  <= 1'b0;
        read_isr_reg <= 1'b0;
        poll_reg     <= 1'b0;
      end
      else
      begin
        if (mode_wr && wd_mode.nest_change_enable)
          special_reg <= wd_mode.special_nest_select;
        if (mode_wr && wd_mode.read_select_enable)
          read_isr_reg <= wd_mode.read_target_select;
        if (mode_wr && wd_mode.query_command)
          poll_reg <= 1'b1;
        else if (rd)
          poll_reg <= 1'b0;
      end
    end
  end

  // special nesting hides masked in-service bits
  assign isr_eff  = special_reg ? (isr_reg & ~mask_reg) : isr_reg;
  assign pend_eff = pend_reg & ~mask_reg;

  // normal nesting blocks equal and lower levels
  // highest unmasked pending level beating service
  icu_prio_resolve #(.N(ICU_N), .W(ICU_W)) u_req_res (
    .cand     (pend_eff),
    .block    (isr_eff),
    .lowest   (lowest_reg),
    .equal_ok (iw4_reg.extended_nest_select),
    .valid    (res_valid),
    .slot     (res_slot)
  );

  // highest in-service level for unnamed finish
  icu_prio_resolve #(.N(ICU_N), .W(ICU_W)) u_isr_res (
    .cand     (isr_reg),
    .block    (ICU_BYTE_CLR),
    .lowest   (lowest_reg),
    .equal_ok (1'b0),
    .valid    (hi_valid),
    .slot     (hi_slot)
  );

  // seven lowest after init, rotate moves it
  // specify-level names the new lowest slot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lowest_reg <= ICU_LOWEST_RST;
    else if (ce)
    begin
      if (w1)
        lowest_reg <= ICU_LOWEST_RST;
      else if (pfc_wr && wd_pfc.rotate_bit)
      begin
        if (wd_pfc.specify_level_bit)
          lowest_reg <= wd_pfc.target_priority_slot;
        else if (wd_pfc.end_of_service_bit && hi_valid)
          lowest_reg <= hi_slot;
      end
    end
  end

  // acknowledge strobe edges and byte selection
  always_comb
  begin
    ack_fall  = ack_prev && !ack_s2;
    ack_rise  = !ack_prev && ack_s2;
    ack_total = iw4_reg.vector_mode ? ICU_VEC_BYTES : ICU_CALL_BYTES;
    ack_end   = ack_rise && ack_cnt_reg == ack_total;
    cur_slot  = (ack_cnt_reg == ICU_BYTE_FIRST) ? res_slot : ack_slot_reg;
    // master leaves flagged slots to the slave
    // slave answers only for its own number
    resp      = single || (master && !iw3_reg[cur_slot]) ||
                (slave && cas_s2 == iw3_reg[2:0]);
    byte_next = ICU_BYTE_CLR;
    oe_next   = 1'b0;
    if (iw4_reg.vector_mode)
    begin
      // vector style returns one byte on second pulse
      // vector byte is upper five bits plus level
      if (ack_cnt_reg == ICU_BYTE_SECOND)
      begin
        byte_next = {iw2_reg[7:3], cur_slot};
        oe_next   = resp;
      end
    end
    else
    begin
      unique case (ack_cnt_reg)
        ICU_BYTE_FIRST:
        begin
          byte_next = ICU_CALL_OPCODE;
          oe_next   = !slave;
        end
        ICU_BYTE_SECOND:
        begin
          byte_next = iw1_reg.spacing_select ? {iw1_reg.addr_lo, cur_slot, 2'b00}
                                             : {iw1_reg.addr_lo[2:1], cur_slot, 3'b000};
          oe_next   = resp;
        end
        default:
        begin
          byte_next = iw2_reg;
          oe_next   = resp;
        end
      endcase
    end
  end

  // acknowledge sequence, data and cascade pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_cnt_reg  <= ICU_BYTE_FIRST;
      ack_slot_reg <= ICU_LOWEST_RST;
      data_reg     <= ICU_BYTE_CLR;
      data_oe_reg  <= 1'b0;
      cas_out_reg  <= '0;
      cas_oe_reg   <= 1'b0;
      sv_out_reg   <= 1'b1;
      sv_oe_reg    <= 1'b0;
    end
    else if (ce)
    begin
      cas_oe_reg <= !slave;
      sv_oe_reg  <= iw4_reg.buffered;
      sv_out_reg <= !data_oe_reg;
      if (ack_fall)
      begin
        ack_cnt_reg <= 2'(ack_cnt_reg + 2'd1);
        data_reg    <= byte_next;
        data_oe_reg <= oe_next;
        if (ack_cnt_reg == ICU_BYTE_FIRST)
        begin
          ack_slot_reg <= res_slot;
          // master drives flagged slot on cascade bus
          if (master && iw3_reg[res_slot])
            cas_out_reg <= res_slot;
        end
      end
      else if (ack_rise)
      begin
        data_oe_reg <= 1'b0;
        if (ack_end)
        begin
          ack_cnt_reg <= ICU_BYTE_FIRST;
          cas_out_reg <= '0;
        end
      end
    end
  end

  // pending and in-service registers
  always_comb
  begin
    pend_next = pend_reg;
    isr_next  = isr_reg;
    // level sensing follows the pin, else rising edge
    if (iw1_reg.sensitivity_select)
      pend_next = req_s2;
    else
    begin
      if (ack_fall && ack_cnt_reg == ICU_BYTE_FIRST && res_valid)
        pend_next[res_slot] = 1'b0;
      if (rd && poll_reg && res_valid)
        pend_next[res_slot] = 1'b0;
      pend_next = pend_next | (req_s2 & ~req_prev);
    end
    pend_next = pend_next & ~mask_reg;
    // finish clears named or highest service bit
    if (pfc_wr && wd_pfc.end_of_service_bit)
    begin
      if (wd_pfc.specify_level_bit)
        isr_next[wd_pfc.target_priority_slot] = 1'b0;
      else if (hi_valid)
        isr_next[hi_slot] = 1'b0;
    end
    // auto end of service at sequence end
    if (ack_end && iw4_reg.auto_end_of_service)
      isr_next[ack_slot_reg] = 1'b0;
    if ((ack_fall && ack_cnt_reg == ICU_BYTE_FIRST || rd && poll_reg) && res_valid)
      isr_next[res_slot] = 1'b1;
  end

  // init resets edge detect, edge pending and service
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_reg <= ICU_BYTE_CLR;
      isr_reg  <= ICU_BYTE_CLR;
      req_prev <= ICU_EDGE_RST;
    end
    else if (ce)
    begin
      if (w1)
      begin
        req_prev <= ICU_EDGE_RST;
        isr_reg  <= ICU_BYTE_CLR;
        pend_reg <= wd_iw1.sensitivity_select ? (req_s2 & ~mask_reg) : ICU_BYTE_CLR;
      end
      else
      begin
        req_prev <= req_s2;
        isr_reg  <= isr_next;
        pend_reg <= pend_next;
      end
    end
  end

  // request line and host read data
  always_comb
  begin
    poll_word       = icu_poll_t'(ICU_BYTE_CLR);
    poll_word.valid = res_valid;
    poll_word.slot  = res_slot;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_req_reg <= 1'b0;
      rd_data_reg <= ICU_BYTE_CLR;
    end
    else if (ce)
    begin
      int_req_reg <= res_valid && state_reg == ICU_READY && ack_cnt_reg == ICU_BYTE_FIRST;
      if (rd)
      begin
        if (poll_reg)
          rd_data_reg <= poll_word;
        else if (host.a0)
          rd_data_reg <= mask_reg;
        else
          rd_data_reg <= read_isr_reg ? isr_reg : pend_reg;
      end
    end
  end

  assign int_req                = int_req_reg;
  assign rd_data                = rd_data_reg;
  assign data_out               = data_reg;
  assign data_oe                = data_oe_reg;
  assign cascade_select_bus_out = cas_out_reg;
  assign cascade_select_bus_oe  = cas_oe_reg;
  assign role_select_pin_out    = sv_out_reg;
  assign role_select_pin_oe     = sv_oe_reg;

  sequence s_init;
    w1;
  endsequence
  sequence s_word2;
    wa1 && state_reg == ICU_WAIT2;
  endsequence

  AST_INIT_CLEARS: assert property (s_init |=> isr_reg == ICU_BYTE_CLR && mask_reg == ICU_BYTE_CLR)
    else $error("init did not clear service and mask");
  AST_INIT_START: assert property (s_init |=> state_reg == ICU_WAIT2)
    else $error("init word did not start sequence");
  AST_INIT_MODES: assert property (s_init |=> !special_reg && !read_isr_reg)
    else $error("init left special nesting or service read");
  AST_IW4_CLEAR: assert property (s_init |=> iw4_reg == icu_iw4_t'(ICU_BYTE_CLR))
    else $error("init did not clear fourth word");
  AST_SEQ_NEXT: assert property (s_word2 |=> state_reg == (!iw1_reg.standalone_select ? ICU_WAIT3 :
      (iw1_reg.fourth_word_needed ? ICU_WAIT4 : ICU_READY)))
    else $error("wrong word expected after second word");
  AST_MASK_LOAD: assert property (mask_wr && !w1 |=> mask_reg == $past(host.wdata))
    else $error("mask word not stored");
  AST_LOWEST_RST: assert property (s_init ##1 !(pfc_wr && wd_pfc.rotate_bit)[*2] |-> lowest_reg == ICU_LOWEST_RST)
    else $error("lowest slot not seven after init");
  AST_EDGE_ONLY: assert property (!iw1_reg.sensitivity_select && !$past(w1) && $rose(pend_reg[0])
      |-> $past(req_s2[0]) && !$past(req_prev[0]))
    else $error("edge pending set without rising edge");
  AST_MASKED_OUT: assert property ((pend_reg & $past(mask_reg)) == ICU_BYTE_CLR)
    else $error("masked request reached pending");

endmodule : icu_core

// >>> icu_host_model.sv
/*
  host processor model: writes control words, reads them back
  and pulses the acknowledge strobe.
  assumes the bench calls its tasks; drives 2 ns after rising clk.
*/
`timescale 1ns/1ps
module icu_host_model (
  // clock
  input  wire logic             clk,
  // device answers
  input  wire logic [7:0]       rd_data,
  input  wire logic [7:0]       data_out,
  input  wire logic             data_oe,
  // host strobes
  output icu_pkg::icu_host_t    host,
  output logic                  ack_n
);
  import icu_pkg::*;

  initial
  begin
    host = '0;
    ack_n = 1'b1;
  end

  // one-cycle write, data inverted once released
  task automatic wr(input logic a0, input logic [7:0] d);
    @(posedge clk);
    #2;
    host = '{1'b1, 1'b0, a0, d};
    @(posedge clk);
    #2;
    host = '{1'b0, 1'b0, a0, ~d};
  endtask : wr

  task automatic rd(input logic a0, output logic [7:0] q);
    @(posedge clk);
    #2;
    host = '{1'b0, 1'b1, a0, host.wdata};
    @(posedge clk);
    #2;
    host.rd = 1'b0;
    q = rd_data;
  endtask : rd

  task automatic init(input logic [7:0] w1, input logic [7:0] w2,
                      input logic [7:0] w3, input logic [7:0] w4);
    wr(1'b0, w1);
    wr(1'b1, w2);
    if (!w1[1])
      wr(1'b1, w3);
    if (w1[0])
      wr(1'b1, w4);
  endtask : init

  // one acknowledge pulse, byte taken before release
  task automatic ack(output logic [7:0] q, output logic oe);
    @(posedge clk);
    #2;
    ack_n = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    q = data_out;
    oe = data_oe;
    ack_n = 1'b1;
    repeat (6) @(posedge clk);
  endtask : ack
endmodule : icu_host_model

// >>> icu_control_word_programming_bench.sv
/*
  self-checking bench: init sequences, mask, finish and acknowledge bytes.
  assumes icu_host_model as host; 40 MHz clock, 8-cycle reset.
*/
`timescale 1ns/1ps
module icu_control_word_programming_bench;
  import icu_pkg::*;
  logic       clk;
  logic       rst_n;
  logic [7:0] req;
  icu_host_t  host;
  logic       ack_n;
  logic [7:0] rd_data;
  logic       int_req;
  logic [7:0] data_out;
  logic       data_oe;
  int         n_errors;
  int         compares;
  int         exp_q[$];
  logic [7:0] b;
  logic [7:0] w2;
  logic [7:0] m;
  int         s;
  int         a;

  icu_core icu_core_i (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .host(host), .rd_data(rd_data),
    .request_input(req), .acknowledge_strobe_n(ack_n), .int_req(int_req),
    .data_out(data_out), .data_oe(data_oe), .role_select_pin_in(1'b1),
    .role_select_pin_out(), .role_select_pin_oe(), .cascade_select_bus_in(3'h0),
    .cascade_select_bus_out(), .cascade_select_bus_oe()
  );

  icu_host_model icu_host_model_i (
    .clk(clk), .rd_data(rd_data), .data_out(data_out), .data_oe(data_oe), .host(host), .ack_n(ack_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test();
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // bounded wait for request, then n pulses; -1 means byte not checked
  task automatic serve(input int n);
    int i;
    int e;
    logic o;
    for (i = 0; i < 60 && int_req !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (int_req !== 1'b1)
    begin
      n_errors++;
      end_of_test();
    end
    repeat (n)
    begin
      icu_host_model_i.ack(b, o);
      e = exp_q.pop_front();
      check({7'h00, o}, {7'h00, e >= 0});
      if (e >= 0)
        check(b, 8'(e));
    end
  endtask : serve

  initial
  begin
    rst_n = 1'b0;
    req = 8'h00;
    n_errors = 0;
    compares = 0;
    s = $urandom(64777);
    repeat (8) @(posedge clk);
    #2;
    rst_n = 1'b1;
    // vector style with auto end of service
    w2 = 8'($urandom);
    icu_host_model_i.init(8'h13, w2, 8'h00, 8'h03);
    icu_host_model_i.wr(1'b1, 8'h00);
    req = 8'h08;
    exp_q = '{-1, {w2[7:3], 3'h3}};
    serve(2);
    icu_host_model_i.wr(1'b0, 8'h0b);
    icu_host_model_i.rd(1'b0, b);
    check(b, 8'h00);
    m = 8'($urandom) | 8'h20;
    icu_host_model_i.wr(1'b1, m);
    icu_host_model_i.rd(1'b1, b);
    check(b, m);
    req = 8'h28;
    repeat (10) @(posedge clk);
    #2;
    check({7'h00, int_req}, 8'h00);
    // call style, both spacings, re-init from ready state
    for (a = 0; a < 2; a++)
    begin
      req = 8'h00;
      w2 = 8'($urandom);
      b = {3'($urandom), 1'b1, 1'b0, 1'(a), 2'b10};
      icu_host_model_i.init(b, w2, 8'h00, 8'h00);
      icu_host_model_i.rd(1'b1, m);
      check(m, 8'h00);
      s = $urandom % 8;
      req[s] = 1'b1;
      exp_q = '{8'hcd, a ? {b[7:5], 3'(s), 2'b00} : {b[7:6], 3'(s), 3'b000}, w2};
      serve(3);
      icu_host_model_i.rd(1'b0, m);
      check(m, 8'h00);
      icu_host_model_i.wr(1'b0, 8'h0b);
      icu_host_model_i.rd(1'b0, m);
      check(m, 8'(1 << s));
      icu_host_model_i.wr(1'b0, 8'h60 | 8'(s));
      icu_host_model_i.rd(1'b0, m);
      check(m, 8'h00);
    end
    // polling read acts as an acknowledge
    req = 8'h00;
    repeat (4) @(posedge clk);
    #2;
    req = 8'h40;
    repeat (6) @(posedge clk);
    #2;
    icu_host_model_i.wr(1'b0, 8'h0c);
    icu_host_model_i.rd(1'b0, m);
    check(m, 8'h86);
    icu_host_model_i.rd(1'b0, m);
    check(m, 8'h40);
    end_of_test();
  end
endmodule : icu_control_word_programming_bench
